// *** hdl/fsb_bridge.sv ***
// Passive fieldbus slave that bridges cyclic I/O buffers into host data memory.
// How it works
// - Bit enable divider covers every supported baud.
// - Station address comes from rotary switches.
// - Switch change takes effect only at power-up.
// - Passive: answers only when master asks.
// - Each exchange takes outputs and returns inputs.
// - Exception flag raised; master then reads diagnostics.
// - Only owning master may write; others read.
// - Buffer lengths span zero to 128 bytes.
// - Output buffer base comes from parameter data.
// - Buffer sizes derive from the configuration bytes.
// - Base and lengths reported to host status.
// - Whole buffers move as one unit.
// - Outputs arrive whole, written to memory together.
// - Inputs read together, sent in one message.
// - Every output message answered with input buffer.
// - Configuration holds up to two slots.
// - Peer protocol reads still served when owned.
// - Input buffer follows output buffer directly.
// - Buffer base defaults to first memory byte.
// - Outputs land before scan, inputs after.
`timescale 1ns/1ps
module fsb_bridge
   import fsb_pkg::*;
#(
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   input  wire logic                CLK_SYS,
   input  wire logic                SYS_RST,
   input  wire logic [6:0]          STATION_SW,
   input  wire logic [BAUD_DIV_W-1:0] BAUD_DIV,
   output logic                     BIT_EN,
   output logic [6:0]               STATION_ADDR,
   input  wire fsb_pkg::fsb_rx_t    RX,
   input  wire logic                RX_VALID,
   output logic                     RX_READY,
   output fsb_pkg::fsb_tx_t         TX,
   output logic                     TX_VALID,
   input  wire logic                TX_READY,
   input  wire logic                EXCEPTION_REQ,
   output logic                     DIAG_PENDING,
   output fsb_pkg::fsb_mem_t        MEM_REQ,
   output logic                     MEM_VALID,
   input  wire logic                MEM_READY,
   input  wire logic [7:0]          MEM_RDATA,
   input  wire logic                MEM_RVALID,
   output logic                     MEM_LOCK,
   input  wire logic                SCAN_PRE,
   input  wire logic                SCAN_POST,
   output fsb_pkg::fsb_report_t     REPORT,
   output logic                     DATA_EXCHANGE,
   output logic                     OWNED,
   output logic [6:0]               OWNER_ADDR
);
   import fsb_pkg::*;

   typedef struct packed {
      fsb_state_t        state;
      logic              strap_done;
      logic [6:0]        station;
      logic [6:0]        owner;
      logic              owned;
      logic [ADDR_W-1:0] base;
      logic [LEN_W-1:0]  out_len;
      logic [LEN_W-1:0]  in_len;
      logic [1:0]        slot;
      logic [7:0]        prm_idx;
      logic [LEN_W-1:0]  idx;
      logic [LEN_W-1:0]  rd_idx;
      logic              out_ready;
      logic              diag;
      logic              report_valid;
      logic              resp_pend;
      logic [LEN_W-1:0]  tx_idx;
      logic [BAUD_DIV_W-1:0] baud_cnt;
      logic              bit_en;
      logic [6:0]        sw_s1;
      logic [6:0]        sw_s2;
      logic [1:0]        pre_s;
      logic [1:0]        post_s;
      logic [1:0]        exc_s;
      logic [7:0]        tx_data;
      logic              tx_last;
      logic              tx_valid;
   } fsb_st_t;

   fsb_st_t          st_r;
   fsb_st_t          st_nxt;
   logic [7:0]       in_buf  [MAX_LEN];
   logic [7:0]       fifo_out;
   logic             fifo_ovalid;
   logic             fifo_oready;
   logic             fifo_iready;
   logic             rx_take;
   logic             is_write;
   logic             from_owner;
   logic             for_data;

   // Output bytes of a data frame pass the FIFO; its ready stalls the link.
   assign for_data   = (RX.kind == FSB_FRM_DATA) && (st_r.state == FSB_DATA_EX);
   assign from_owner = st_r.owned && (RX.src == st_r.owner);
   assign is_write   = (RX.kind == FSB_FRM_PARAM) || (RX.kind == FSB_FRM_CONFIG)
                       || (RX.kind == FSB_FRM_DATA);
   assign RX_READY   = !st_r.resp_pend && (!for_data || fifo_iready);
   assign rx_take    = RX_VALID && RX_READY;
   assign fifo_oready = (st_r.state == FSB_OUT_XFER) && MEM_READY;

   fsb_fifo #(
      .WIDTH (8),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (CLK_SYS),
      .rst       (SYS_RST),
      .in_data   (RX.data),
      .in_valid  (RX_VALID && for_data && !st_r.resp_pend && from_owner),
      .in_ready  (fifo_iready),
      .out_data  (fifo_out),
      .out_valid (fifo_ovalid),
      .out_ready (fifo_oready)
   );

   // Next state of the whole bridge.
   always_comb begin
      st_nxt = st_r;
      // Two-stage synchronisers for pins.
      st_nxt.sw_s1  = STATION_SW;
      st_nxt.sw_s2  = st_r.sw_s1;
      st_nxt.pre_s  = {st_r.pre_s[0], SCAN_PRE};
      st_nxt.post_s = {st_r.post_s[0], SCAN_POST};
      st_nxt.exc_s  = {st_r.exc_s[0], EXCEPTION_REQ};
      // Bit enable divider; divisors 2 to 2603 yield a baud in range.
      st_nxt.bit_en = 1'b0;
      if (st_r.baud_cnt == '0) begin
         st_nxt.baud_cnt = BAUD_DIV;
         st_nxt.bit_en   = 1'b1;
      end else begin
         st_nxt.baud_cnt = st_r.baud_cnt - 1'b1;
      end
      // The address is caught once after reset and then held.
      if (!st_r.strap_done && st_r.baud_cnt == '0) begin
         st_nxt.station    = st_r.sw_s2;
         st_nxt.strap_done = 1'b1;
      end
      // Exception is sticky; the diagnostic read clears it but a new one wins.
      if (st_r.diag && rx_take && RX.last && RX.kind == FSB_FRM_DIAG) begin
         st_nxt.diag = 1'b0;
      end
      if (st_r.exc_s[1]) begin
         st_nxt.diag = 1'b1;
      end
      // Transmit handshake.
      if (st_r.tx_valid && TX_READY) begin
         st_nxt.tx_valid = 1'b0;
         if (st_r.tx_last) begin
            st_nxt.resp_pend = 1'b0;
         end else begin
            st_nxt.tx_idx = st_r.tx_idx + 1'b1;
         end
      end
      // The response streams the snapshot of the input buffer only.
      if (st_r.resp_pend && !st_r.tx_valid && !(st_r.tx_valid && TX_READY)) begin
         st_nxt.tx_data  = in_buf[st_r.tx_idx];
         st_nxt.tx_last  = (st_r.tx_idx == st_r.in_len - 1'b1);
         st_nxt.tx_valid = 1'b1;
      end
      // Received byte handling; nothing is ever sent unasked.
      if (rx_take) begin
         unique case (RX.kind)
            FSB_FRM_PARAM: begin
               if (!st_r.owned || from_owner) begin
                  if (RX.first) begin
                     st_nxt.prm_idx = 8'h01;
                     st_nxt.base    = {8'h00, RX.data};
                  end else begin
                     st_nxt.prm_idx = st_r.prm_idx + 1'b1;
                     if (st_r.prm_idx == 8'h01) begin
                        st_nxt.base = {st_r.base[7:0], RX.data};
                     end
                  end
                  if (RX.last) begin
                     st_nxt.owner = RX.src;
                     st_nxt.state = FSB_WAIT_CFG;
                     st_nxt.owned = 1'b0;
                     st_nxt.report_valid = 1'b0;
                  end
               end
            end
            FSB_FRM_CONFIG: begin
               if (st_r.state == FSB_WAIT_CFG && RX.src == st_r.owner) begin
                  if (RX.first) begin
                     st_nxt.slot    = 2'h0;
                     st_nxt.out_len = '0;
                     st_nxt.in_len  = '0;
                  end
                  // Each slot byte: bit7 out, bit6 in, low bits length minus one.
                  if (RX.first || st_r.slot < 2'(NUM_SLOTS)) begin
                     st_nxt.slot = (RX.first ? 2'h0 : st_r.slot) + 2'h1;
                     if (RX.data[7]) begin
                        st_nxt.out_len = len_add(RX.first ? '0 : st_r.out_len,
                                                 cfg_len(RX.data));
                     end
                     if (RX.data[6]) begin
                        st_nxt.in_len = len_add(RX.first ? '0 : st_r.in_len,
                                                cfg_len(RX.data));
                     end
                  end
                  if (RX.last) begin
                     st_nxt.state = FSB_WAIT_DIAG;
                  end
               end
            end
            FSB_FRM_DIAG: begin
               // Diagnostic read confirms acceptance and grants ownership.
               if (st_r.state == FSB_WAIT_DIAG && RX.last && RX.src == st_r.owner) begin
                  st_nxt.owned        = 1'b1;
                  st_nxt.report_valid = 1'b1;
                  st_nxt.state        = FSB_DATA_EX;
               end
            end
            FSB_FRM_DATA: begin
               if (for_data && from_owner && RX.last) begin
                  st_nxt.resp_pend = 1'b1;
                  st_nxt.tx_idx    = '0;
                  st_nxt.out_ready = 1'b1;
               end
            end
            FSB_FRM_READ, FSB_FRM_PEER: begin
               // Any master may read the inputs, but only once the bridge is owned.
               if (RX.last && st_r.owned) begin
                  st_nxt.resp_pend = 1'b1;
                  st_nxt.tx_idx    = '0;
               end
            end
            default: begin
            end
         endcase
      end
      // Scan hooks move whole buffers while the memory is locked.
      unique case (st_r.state)
         FSB_DATA_EX: begin
            if (st_r.pre_s[1] && st_r.out_ready) begin
               st_nxt.state = FSB_OUT_XFER;
               st_nxt.idx   = '0;
            end else if (st_r.post_s[1] && !st_r.resp_pend) begin
               st_nxt.state  = FSB_IN_XFER;
               st_nxt.idx    = '0;
               st_nxt.rd_idx = '0;
            end
         end
         FSB_OUT_XFER: begin
            if (fifo_ovalid && MEM_READY) begin
               st_nxt.idx = st_r.idx + 1'b1;
               if (st_r.idx == st_r.out_len - 1'b1) begin
                  st_nxt.state     = FSB_DATA_EX;
                  st_nxt.out_ready = 1'b0;
               end
            end
         end
         FSB_IN_XFER: begin
            if (MEM_READY && st_r.idx != st_r.in_len) begin
               st_nxt.idx = st_r.idx + 1'b1;
            end
            if (MEM_RVALID) begin
               st_nxt.rd_idx = st_r.rd_idx + 1'b1;
               if (st_r.rd_idx == st_r.in_len - 1'b1) begin
                  st_nxt.state    = FSB_DATA_EX;
               end
            end
         end
         default: begin
         end
      endcase
   end

   // Register the state; the address strap is caught after release.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         st_r         <= '0;
         st_r.state   <= FSB_WAIT_PRM;
         st_r.station <= STATION_RST;
         st_r.base    <= BUF_BASE_RST;
         st_r.out_len <= LEN_W'(MIN_LEN);
         st_r.in_len  <= LEN_W'(MIN_LEN);
         st_r.baud_cnt <= BAUD_CNT_RST;
      end else begin
         st_r <= st_nxt;
      end
      // Input snapshot, written only inside a whole-buffer move.
      if (st_r.state == FSB_IN_XFER && MEM_RVALID) begin
         in_buf[st_r.rd_idx] <= MEM_RDATA;
      end
   end

   // Memory requests; input buffer sits right after the output buffer.
   always_comb begin
      MEM_REQ   = '0;
      MEM_VALID = 1'b0;
      if (st_r.state == FSB_OUT_XFER) begin
         MEM_REQ.wr   = 1'b1;
         MEM_REQ.addr = st_r.base + ADDR_W'(st_r.idx);
         MEM_REQ.data = fifo_out;
         MEM_VALID    = fifo_ovalid;
      end else if (st_r.state == FSB_IN_XFER && st_r.idx != st_r.in_len) begin
         MEM_REQ.addr = st_r.base + ADDR_W'(st_r.out_len) + ADDR_W'(st_r.idx);
         MEM_VALID    = 1'b1;
      end
   end

   // Lock keeps user interrupts off the memory during a move.
   assign MEM_LOCK      = (st_r.state == FSB_OUT_XFER) || (st_r.state == FSB_IN_XFER);
   assign BIT_EN        = st_r.bit_en;
   assign STATION_ADDR  = st_r.station;
   assign TX.data       = st_r.tx_data;
   assign TX.last       = st_r.tx_last;
   assign TX_VALID      = st_r.tx_valid;
   assign DIAG_PENDING  = st_r.diag;
   assign REPORT.valid  = st_r.report_valid;
   assign REPORT.base   = st_r.base;
   assign REPORT.out_len = st_r.out_len;
   assign REPORT.in_len = st_r.in_len;
   assign DATA_EXCHANGE = st_r.owned;
   assign OWNED         = st_r.owned;
   assign OWNER_ADDR    = st_r.owner;

endmodule

// *** hdl/fsb_pkg.sv ***
// Package with shared constants, types and carriers of the fieldbus slave buffer bridge.
package fsb_pkg;

   // Buffer sizing.
   localparam int unsigned MAX_LEN        = 244;
   localparam int unsigned MIN_LEN        = 1;
   localparam int unsigned LEN_W          = 8;
   localparam int unsigned ADDR_W         = 16;
   localparam int unsigned NUM_SLOTS      = 2;
   localparam int unsigned FIFO_DEPTH     = 16;

   // Reset values.
   localparam logic [ADDR_W-1:0] BUF_BASE_RST = 16'h0000;
   localparam logic [6:0]        STATION_RST  = 7'h7e;

   // Baud limits and the one-cycle bit enable rate.
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned BAUD_MIN       = 9600;
   localparam int unsigned BAUD_MAX       = 12_000_000;
   localparam int unsigned BAUD_DIV_W     = 12;
   localparam logic [BAUD_DIV_W-1:0] BAUD_CNT_RST = 12'h002;

   // Frame kinds presented by the link layer.
   typedef enum logic [2:0] {
      FSB_FRM_PARAM = 3'h0,
      FSB_FRM_CONFIG = 3'h1,
      FSB_FRM_DIAG  = 3'h2,
      FSB_FRM_DATA  = 3'h3,
      FSB_FRM_READ  = 3'h4,
      FSB_FRM_PEER  = 3'h5
   } fsb_frame_t;

   // Startup sequence states, Gray coded along the usual path.
   typedef enum logic [2:0] {
      FSB_WAIT_PRM = 3'b000,
      FSB_WAIT_CFG = 3'b001,
      FSB_WAIT_DIAG = 3'b011,
      FSB_DATA_EX  = 3'b010,
      FSB_OUT_XFER = 3'b110,
      FSB_IN_XFER  = 3'b111
   } fsb_state_t;

   // One byte of a received fieldbus frame.
   typedef struct packed {
      logic [6:0]  src;
      fsb_frame_t  kind;
      logic        first;
      logic        last;
      logic [7:0]  data;
   } fsb_rx_t;

   // One byte of a response frame.
   typedef struct packed {
      logic        last;
      logic [7:0]  data;
   } fsb_tx_t;

   // Host data memory write or read request.
   typedef struct packed {
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } fsb_mem_t;

   // Configuration report for the host status memory.
   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] base;
      logic [LEN_W-1:0]  out_len;
      logic [LEN_W-1:0]  in_len;
   } fsb_report_t;

   // Length carried in one configuration byte, counted from one.
   function automatic logic [LEN_W-1:0] cfg_len(input logic [7:0] b);
      return {2'h0, b[5:0]} + 8'h01;
   endfunction

   // Saturating sum of two slot lengths.
   function automatic logic [LEN_W-1:0] len_add(input logic [LEN_W-1:0] a,
                                                input logic [LEN_W-1:0] b);
      logic [LEN_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      return (s > (LEN_W+1)'(MAX_LEN)) ? LEN_W'(MAX_LEN) : s[LEN_W-1:0];
   endfunction

endpackage

// *** hdl/fsb_fifo.sv ***
// Synchronous valid/ready FIFO with parameterised width and depth.
`timescale 1ns/1ps
module fsb_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } fsb_fifo_st_t;

   logic [WIDTH-1:0] mem [DEPTH];
   fsb_fifo_st_t     st_r;
   fsb_fifo_st_t     st_nxt;
   logic             push;
   logic             pop;

   // Full and empty come straight from the fill count.
   assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_r.cnt != '0);
   assign out_data  = mem[st_r.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer and count update.
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
      if (push && !pop) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end else if (pop && !push) begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end
   end

   // State register; storage needs no reset.
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
      if (push) begin
         mem[st_r.wp] <= in_data;
      end
   end

endmodule

// *** tb/fsb_bridge_properties.sv ***
// Concurrent checks on the ports of the fieldbus slave buffer bridge.
`timescale 1ns/1ps
module fsb_bridge_properties
   import fsb_pkg::*;
(
   input wire logic                  CLK_SYS,
   input wire logic                  SYS_RST,
   input wire logic [BAUD_DIV_W-1:0] BAUD_DIV,
   input wire logic                  BIT_EN,
   input wire logic [6:0]            STATION_ADDR,
   input wire fsb_pkg::fsb_rx_t      RX,
   input wire logic                  RX_VALID,
   input wire logic                  RX_READY,
   input wire fsb_pkg::fsb_tx_t      TX,
   input wire logic                  TX_VALID,
   input wire logic                  TX_READY,
   input wire logic                  EXCEPTION_REQ,
   input wire logic                  DIAG_PENDING,
   input wire fsb_pkg::fsb_mem_t     MEM_REQ,
   input wire logic                  MEM_VALID,
   input wire logic                  MEM_READY,
   input wire logic                  MEM_LOCK,
   input wire fsb_pkg::fsb_report_t  REPORT,
   input wire logic                  DATA_EXCHANGE,
   input wire logic                  OWNED,
   input wire logic [6:0]            OWNER_ADDR
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);
   logic [BAUD_DIV_W-1:0] gap_r;
   logic [1:0]            nbit_r;
   // Count cycles since the last bit pulse and up to two pulses seen since reset.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         gap_r <= '0;
         nbit_r <= 2'h0;
      end else begin
         gap_r <= BIT_EN ? '0 : gap_r + 1'b1;
         nbit_r <= (BIT_EN && nbit_r != 2'h2) ? nbit_r + 2'h1 : nbit_r;
      end
   end
   a_bit_period: assert property (BIT_EN && nbit_r != 2'h0 |-> gap_r == BAUD_DIV)
      else $error("bit spacing");
   a_station_frozen: assert property (nbit_r == 2'h2 |-> $stable(STATION_ADDR))
      else $error("station address moved");
   a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX))
      else $error("response byte not held");
   a_mem_hold: assert property (MEM_VALID && !MEM_READY |=> MEM_VALID && $stable(MEM_REQ))
      else $error("memory request not held");
   a_mem_locked: assert property (MEM_VALID |-> MEM_LOCK)
      else $error("access while unlocked");
   a_exchange_owned: assert property (DATA_EXCHANGE |-> OWNED && REPORT.valid)
      else $error("exchange without setup");
   a_foreign_ignored: assert property (RX_VALID && RX_READY && OWNED && RX.src != OWNER_ADDR
      && RX.kind inside {FSB_FRM_PARAM, FSB_FRM_CONFIG} |=> $stable(REPORT) && $stable(OWNER_ADDR))
      else $error("foreign write accepted");
   a_exc_flag: assert property ($rose(EXCEPTION_REQ) |-> ##[1:5] DIAG_PENDING)
      else $error("diag flag not raised");
   a_len_range: assert property (REPORT.valid |-> REPORT.out_len <= 8'hf4 && REPORT.in_len <= 8'hf4)
      else $error("length above maximum");
   c_exchange: cover property ($rose(DATA_EXCHANGE));
   c_out_write: cover property (MEM_VALID && MEM_READY && MEM_REQ.wr);
   c_in_read: cover property (MEM_VALID && MEM_READY && !MEM_REQ.wr);
endmodule
bind fsb_bridge fsb_bridge_properties props_inst (.CLK_SYS, .SYS_RST, .BAUD_DIV, .BIT_EN,
   .STATION_ADDR, .RX, .RX_VALID, .RX_READY, .TX, .TX_VALID, .TX_READY, .EXCEPTION_REQ,
   .DIAG_PENDING, .MEM_REQ, .MEM_VALID, .MEM_READY, .MEM_LOCK, .REPORT, .DATA_EXCHANGE,
   .OWNED, .OWNER_ADDR);

// *** tb/fsb_master_model.sv ***
// Fieldbus master model: sends frames, collects response bytes.
`timescale 1ns/1ps
module fsb_master_model
   import fsb_pkg::*;
(
   input wire logic         clk,
   output fsb_pkg::fsb_rx_t rx,
   output logic             rx_valid,
   input wire logic         rx_ready,
   input wire fsb_pkg::fsb_tx_t tx,
   input wire logic         tx_valid,
   output logic             tx_ready
);
   logic [7:0] resp[$];
   int         nframes = 0;
   logic       slow = 1'b0;
   logic       hs = 1'b0;
   initial begin
      rx = '0;
      rx_valid = 1'b0;
      tx_ready = 1'b1;
   end
   // Track taken bytes and store response bytes.
   always @(posedge clk) begin
      hs <= rx_valid && rx_ready;
      if (tx_valid && tx_ready) begin
         resp.push_back(tx.data);
         nframes <= nframes + (tx.last ? 1 : 0);
      end
   end
   // Drop ready every other cycle while slow is set.
   always @(negedge clk) begin
      tx_ready <= !slow || !tx_ready;
   end
   // Send a frame, each byte held until taken, up to 100 cycles.
   task automatic send(input logic [6:0] src, input fsb_frame_t kind, input logic [7:0] b[$]);
      int i;
      int w;
      @(negedge clk);
      for (i = 0; i < b.size(); i++) begin
         rx <= '{src, kind, i == 0, i == b.size() - 1, b[i]};
         rx_valid <= 1'b1;
         w = 0;
         do begin
            @(negedge clk);
            w++;
         end while (!hs && w < 100);
         if (!hs) begin
            break;
         end
      end
      rx_valid <= 1'b0;
      rx <= '{src, kind, 1'b0, 1'b0, ~b[b.size() - 1]};
   endtask
endmodule

// *** tb/fsb_bridge_tb.sv ***
// Self-checking testbench of the fieldbus slave buffer bridge.
`timescale 1ns/1ps
module fsb_bridge_tb;
   import fsb_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [6:0] stn_sw = 7'h05;
   logic [BAUD_DIV_W-1:0] baud_div = 12'h004;
   logic exc = 1'b0;
   logic scan_pre = 1'b0;
   logic scan_post = 1'b0;
   logic mem_ready = 1'b0;
   logic mem_rvalid = 1'b0;
   logic [7:0] mem_rdata = 8'h00;
   logic bit_en, rx_valid, rx_ready, tx_valid, tx_ready, diag_pend, mem_valid, mem_lock;
   logic dx, owned;
   logic [6:0] stn, owner;
   fsb_rx_t rx;
   fsb_tx_t tx;
   fsb_mem_t mem_req;
   fsb_report_t report;
   logic [7:0] mem [0:65535];
   logic [15:0] rq[$];
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int nb;
   fsb_bridge fsb_bridge_inst (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .STATION_SW(stn_sw),
      .BAUD_DIV(baud_div), .BIT_EN(bit_en), .STATION_ADDR(stn), .RX(rx), .RX_VALID(rx_valid),
      .RX_READY(rx_ready), .TX(tx), .TX_VALID(tx_valid), .TX_READY(tx_ready),
      .EXCEPTION_REQ(exc), .DIAG_PENDING(diag_pend), .MEM_REQ(mem_req), .MEM_VALID(mem_valid),
      .MEM_READY(mem_ready), .MEM_RDATA(mem_rdata), .MEM_RVALID(mem_rvalid),
      .MEM_LOCK(mem_lock), .SCAN_PRE(scan_pre), .SCAN_POST(scan_post), .REPORT(report),
      .DATA_EXCHANGE(dx), .OWNED(owned), .OWNER_ADDR(owner));
   fsb_master_model mst (.clk(clk_sys), .rx(rx), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .tx(tx), .tx_valid(tx_valid), .tx_ready(tx_ready));
   // Clock at 25 MHz.
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   // Host memory accepts requests and queues read addresses.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         tally_and_finish;
      end
      if (mem_valid && mem_ready) begin
         if (mem_req.wr) begin
            mem[mem_req.addr] = mem_req.data;
         end else begin
            rq.push_back(mem_req.addr);
         end
      end
   end
   // Host memory returns reads in order and drops ready every other cycle.
   always @(negedge clk_sys) begin
      mem_ready <= !mem_ready;
      mem_rvalid <= rq.size() > 0;
      mem_rdata <= (rq.size() > 0) ? mem[rq.pop_front()] : ~mem_rdata;
   end
   task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_bit(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Wait, bounded, for a buffer move to start and finish.
   task automatic wait_lock;
      int k = 0;
      while (!mem_lock && k++ < 60) begin
         idle(1);
      end
      while (mem_lock && k++ < 300) begin
         idle(1);
      end
      check_bit("move ended", 1'b0, mem_lock);
   endtask
   task automatic wait_resp(input int n);
      int k = 0;
      while (mst.nframes < n && k++ < 300) begin
         idle(1);
      end
      check_val("frames", 16'(n), 16'(mst.nframes));
   endtask
   task automatic t_reset;
      check_val("reset base", 16'h0000, report.base);
      check_val("reset lengths", 16'h0101, {report.out_len, report.in_len});
      check_bit("reset owned", 1'b0, owned);
      $display("test reset done");
   endtask
   task automatic t_station;
      idle(20);
      check_val("station", 16'h0005, 16'(stn));
      stn_sw <= 7'h09;
      idle(30);
      check_val("station kept", 16'h0005, 16'(stn));
      $display("test station done");
   endtask
   task automatic t_early_data;
      mst.send(7'h05, FSB_FRM_DATA, '{8'h11});
      idle(30);
      check_val("early answers", 16'h0000, 16'(mst.nframes));
      check_bit("early exchange", 1'b0, dx);
      $display("test early done");
   endtask
   task automatic t_setup;
      mst.send(7'h05, FSB_FRM_PARAM, '{8'h01, 8'h00});
      mst.send(7'h05, FSB_FRM_CONFIG, '{8'hc3, 8'hc1});
      mst.send(7'h05, FSB_FRM_DIAG, '{8'h00});
      idle(40);
      check_bit("report valid", 1'b1, report.valid);
      check_val("base", 16'h0100, report.base);
      check_val("lengths", 16'h0606, {report.out_len, report.in_len});
      check_val("owner", 16'h0005, 16'(owner));
      check_bit("exchange", 1'b1, dx);
      $display("test setup done");
   endtask
   task automatic t_foreign;
      mst.send(7'h09, FSB_FRM_PARAM, '{8'h22, 8'h00});
      idle(10);
      check_val("base kept", 16'h0100, report.base);
      check_val("owner kept", 16'h0005, 16'(owner));
      nb = mst.nframes;
      mst.send(7'h09, FSB_FRM_READ, '{8'h00});
      wait_resp(nb + 1);
      $display("test foreign done");
   endtask
   task automatic t_exchange;
      for (int i = 0; i < 7; i++) begin
         mem[16'h0106 + i] = 8'ha0 + 8'(i);
      end
      mst.slow = 1'b1;
      mst.resp.delete();
      nb = mst.nframes;
      scan_post <= 1'b1;
      idle(3);
      scan_post <= 1'b0;
      wait_lock;
      mst.send(7'h05, FSB_FRM_DATA, '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15});
      wait_resp(nb + 1);
      check_val("input size", 16'h0006, 16'(mst.resp.size()));
      for (int i = 0; i < 6; i++) begin
         check_val("input byte", 16'(8'ha0 + 8'(i)), 16'(mst.resp[i]));
      end
      scan_pre <= 1'b1;
      idle(3);
      scan_pre <= 1'b0;
      wait_lock;
      for (int i = 0; i < 6; i++) begin
         check_val("output byte", 16'(8'h10 + 8'(i)), 16'(mem[16'h0100 + i]));
      end
      check_val("input area kept", 16'h00a0, 16'(mem[16'h0106]));
      $display("test exchange done");
   endtask
   task automatic t_exception;
      exc <= 1'b1;
      idle(6);
      check_bit("diag flag set", 1'b1, diag_pend);
      exc <= 1'b0;
      idle(3);
      mst.send(7'h05, FSB_FRM_DIAG, '{8'h00});
      idle(40);
      check_bit("diag flag clear", 1'b0, diag_pend);
      $display("test exception done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Reset for three cycles, then run every test.
   initial begin
      idle(3);
      sys_rst <= 1'b0;
      t_reset;
      t_station;
      t_early_data;
      t_setup;
      t_foreign;
      t_exchange;
      t_exception;
      tally_and_finish;
   end
endmodule
